/* core/event_type_pkg.sv */
// Constants shared by the activity monitor event-type register bank
package event_type_pkg;
  // --------------------------------------------------------------
  // Bus geometry
  // --------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 2;
  localparam int COUNT_W = 8;

  // --------------------------------------------------------------
  // Register offsets (byte addresses)
  // --------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_EVENT_TYPE_COUNTER_ZERO = 12'h400;
  localparam logic [ADDR_W-1:0] OFS_EVENT_TYPE_COUNTER_ONE = 12'h404;
  localparam logic [ADDR_W-1:0] OFS_EVENT_TYPE_COUNTER_TWO = 12'h408;
  localparam int NUM_TYPE_REGS = 3;

  // --------------------------------------------------------------
  // Field layout
  // --------------------------------------------------------------
  localparam int EVENT_NUMBER_FIELD_LSB = 0;
  localparam int EVENT_NUMBER_FIELD_W = 16;
  localparam int RESERVED_ZERO_LSB = 16;
  localparam int RESERVED_ZERO_W = 16;

  // --------------------------------------------------------------
  // Fixed event numbers
  // --------------------------------------------------------------
  localparam logic [EVENT_NUMBER_FIELD_W-1:0] EVT_PROC_FREQ_CYCLES = 16'h0011;
  localparam logic [EVENT_NUMBER_FIELD_W-1:0] EVT_CONST_FREQ_CYCLES = 16'h4004;

  // --------------------------------------------------------------
  // Reset values of the answer registers
  // --------------------------------------------------------------
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
  localparam logic WRITE_FLAG_RESET = 1'b0;
endpackage

/* core/event_type_lookup.sv */
// Combinational lookup of one event-type register value by index
module event_type_lookup #(
  parameter logic [15:0] INSTR_RETIRED_CODE = 16'h0000
) (
  // Selection
  input wire logic i_hit,
  input wire logic [event_type_pkg::IDX_W-1:0] i_index,
  // Number of architected counters present
  input wire logic [event_type_pkg::COUNT_W-1:0] i_architected_counter_count,
  // Value
  output logic [event_type_pkg::DATA_W-1:0] o_value
);
  logic [event_type_pkg::EVENT_NUMBER_FIELD_W-1:0] event_number_field;
  logic implemented;

  always_comb begin
    case (i_index)
      2'h0: event_number_field = event_type_pkg::EVT_PROC_FREQ_CYCLES;
      2'h1: event_number_field = event_type_pkg::EVT_CONST_FREQ_CYCLES;
      2'h2: event_number_field = INSTR_RETIRED_CODE;
      default: event_number_field = 16'h0000;
    endcase
  end

  // Indices at or past the implemented count read as zero
  assign implemented = {{(event_type_pkg::COUNT_W-event_type_pkg::IDX_W){1'b0}}, i_index}
    < i_architected_counter_count;

  // Upper half is always zero; low half carries the fixed number
  assign o_value = (i_hit && implemented) ?
    {{event_type_pkg::RESERVED_ZERO_W{1'b0}}, event_number_field} :
    {event_type_pkg::DATA_W{1'b0}};
endmodule

/* core/event_type_regs.sv */
// Read-only event-type register bank for the architected activity monitor counters

// What this block does
// - Writes to the event-type registers change nothing; they are only flagged.
// - Bits 31 to 16 of every event-type register always read zero.
// - Bits 15 to 0 hold the fixed event number of the matching counter.
// - Offset 0x400 reports the processor frequency cycles event number.
// - Offset 0x404 reports the constant frequency cycles event number.
// - Offset 0x408 reports the instructions retired event number.
// - Registers at or beyond the implemented counter count read as zero.
// - The implemented counter count comes from the counter group configuration field.
// - The system register view shows exactly the same 32 bits.
module event_type_regs #(
  parameter logic [15:0] INSTR_RETIRED_CODE = 16'h0000,
  parameter int NUM_ARCH_COUNTERS_MAX = event_type_pkg::NUM_TYPE_REGS
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Memory-mapped register port
  input wire logic [event_type_pkg::ADDR_W-1:0] i_addr,
  input wire logic [event_type_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [event_type_pkg::DATA_W-1:0] o_rdata,
  output logic o_write_ignored,
  // System register view
  input wire logic i_sysreg_rd,
  input wire logic [event_type_pkg::IDX_W-1:0] i_sysreg_idx,
  output logic [event_type_pkg::DATA_W-1:0] o_sysreg_rdata,
  // Field of the counter group configuration register
  input wire logic [event_type_pkg::COUNT_W-1:0] i_architected_counter_count
);
  // --------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------
  if (NUM_ARCH_COUNTERS_MAX != event_type_pkg::NUM_TYPE_REGS) begin : g_bad_count
    $error("event_type_regs: only three architected event-type registers are supported");
  end

  // --------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------
  logic rst_meta_b;
  logic rst_sync_b;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // --------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------
  // Unaligned or out-of-window addresses miss, so they read zero like any hole
  function automatic logic type_hit(input logic [event_type_pkg::ADDR_W-1:0] addr);
    type_hit = (addr == event_type_pkg::OFS_EVENT_TYPE_COUNTER_ZERO) ||
               (addr == event_type_pkg::OFS_EVENT_TYPE_COUNTER_ONE) ||
               (addr == event_type_pkg::OFS_EVENT_TYPE_COUNTER_TWO);
  endfunction

  logic bus_hit;
  logic [event_type_pkg::IDX_W-1:0] bus_idx;
  logic sys_hit;
  logic [event_type_pkg::DATA_W-1:0] bus_value;
  logic [event_type_pkg::DATA_W-1:0] sys_value;

  assign bus_hit = type_hit(i_addr);
  assign bus_idx = i_addr[3:2];
  assign sys_hit = ({{(event_type_pkg::COUNT_W-event_type_pkg::IDX_W){1'b0}}, i_sysreg_idx}
    < event_type_pkg::COUNT_W'(event_type_pkg::NUM_TYPE_REGS));

  // --------------------------------------------------------------
  // Value lookup
  // --------------------------------------------------------------
  // One lookup per view from the same table keeps both views identical
  event_type_lookup #(
    .INSTR_RETIRED_CODE(INSTR_RETIRED_CODE)
  ) u_bus_lookup (
    .i_hit(bus_hit),
    .i_index(bus_idx),
    .i_architected_counter_count(i_architected_counter_count),
    .o_value(bus_value)
  );

  event_type_lookup #(
    .INSTR_RETIRED_CODE(INSTR_RETIRED_CODE)
  ) u_sys_lookup (
    .i_hit(sys_hit),
    .i_index(i_sysreg_idx),
    .i_architected_counter_count(i_architected_counter_count),
    .o_value(sys_value)
  );

  // --------------------------------------------------------------
  // Answer registers
  // --------------------------------------------------------------
  logic [event_type_pkg::DATA_W-1:0] next_rdata;
  logic [event_type_pkg::DATA_W-1:0] next_sysreg_rdata;
  logic next_write_ignored;
  logic unused_wdata;

  // Write data is deliberately dropped: the bank holds no writable state
  assign unused_wdata = ^i_wdata;

  always_comb begin
    next_rdata = event_type_pkg::RDATA_RESET;
    next_sysreg_rdata = event_type_pkg::RDATA_RESET;
    if (i_rd) begin
      next_rdata = bus_value;
    end
    if (i_sysreg_rd) begin
      next_sysreg_rdata = sys_value;
    end
    // A write to a mapped offset is reserved: flagged one cycle, stored nowhere
    next_write_ignored = i_wr && bus_hit;
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      o_rdata <= event_type_pkg::RDATA_RESET;
      o_sysreg_rdata <= event_type_pkg::RDATA_RESET;
      o_write_ignored <= event_type_pkg::WRITE_FLAG_RESET;
    end else begin
      o_rdata <= next_rdata;
      o_sysreg_rdata <= next_sysreg_rdata;
      o_write_ignored <= next_write_ignored;
    end
  end
endmodule

/* tb/event_type_regs_props.sv */
// Port checker for the event-type register bank
module event_type_regs_props #(
  parameter logic [15:0] INSTR_RETIRED_CODE = 16'h0000
) (
  // Clock, reset and strobes
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_sysreg_rd,
  // Address, index, count and answers
  input wire logic [11:0] i_addr,
  input wire logic [1:0] i_sysreg_idx,
  input wire logic [7:0] i_architected_counter_count,
  input wire logic [31:0] o_rdata,
  input wire logic [31:0] o_sysreg_rdata,
  input wire logic o_write_ignored
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  logic hit;
  assign hit = i_addr inside {12'h400, 12'h404, 12'h408};
  upper_zero_a: assert property (o_rdata[31:16] == 16'h0 && o_sysreg_rdata[31:16] == 16'h0)
    else $error("upper half not zero");
  rd_idle_a: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("idle rdata not zero");
  evt_zero_a: assert property (i_rd && i_addr == 12'h400 && i_architected_counter_count >= 8'h01 |=>
    o_rdata == 32'h11)
    else $error("counter zero event number wrong");
  evt_one_a: assert property (i_rd && i_addr == 12'h404 && i_architected_counter_count >= 8'h02 |=>
    o_rdata == 32'h4004)
    else $error("counter one event number wrong");
  evt_two_a: assert property (i_rd && i_addr == 12'h408 && i_architected_counter_count >= 8'h03 |=>
    o_rdata == {16'h0, INSTR_RETIRED_CODE})
    else $error("counter two event number wrong");
  beyond_count_a: assert property (i_rd && hit && i_architected_counter_count <= i_addr[3:2] |=>
    o_rdata == 32'h0)
    else $error("register beyond counter count not zero");
  unmapped_read_a: assert property (i_rd && !hit |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  wr_flag_a: assert property (i_wr && hit |=> o_write_ignored)
    else $error("write flag missing");
  wr_quiet_a: assert property (!(i_wr && hit) |=> !o_write_ignored)
    else $error("write flag without write");
  sys_idle_a: assert property (!i_sysreg_rd |=> o_sysreg_rdata == 32'h0)
    else $error("idle sysreg rdata not zero");
  views_mirror_a: assert property (i_sysreg_rd && i_rd && i_addr == {8'h40, i_sysreg_idx, 2'b00} |=>
    o_sysreg_rdata == o_rdata)
    else $error("views differ");
endmodule
bind event_type_regs event_type_regs_props #(.INSTR_RETIRED_CODE(INSTR_RETIRED_CODE)) i_props (.i_sys_clk(i_sys_clk),
  .i_rst_b(i_rst_b), .i_wr(i_wr), .i_rd(i_rd), .i_sysreg_rd(i_sysreg_rd), .i_addr(i_addr), .i_sysreg_idx(i_sysreg_idx),
  .i_architected_counter_count(i_architected_counter_count), .o_rdata(o_rdata), .o_sysreg_rdata(o_sysreg_rdata),
  .o_write_ignored(o_write_ignored));

/* tb/testbench.sv */
// Self-checking bench for the event-type register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary stand-in for the integrator's retired-instruction code
  localparam logic [15:0] RETIRED = 16'h5a5a;
  logic i_sys_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_sysreg_rd = 1'b0, o_write_ignored, e_wi = 1'b0;
  logic [11:0] i_addr = 12'h0;
  logic [1:0] i_sysreg_idx = 2'h0;
  logic [7:0] i_architected_counter_count = 8'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata, o_sysreg_rdata, e_rd = 32'h0, e_sr = 32'h0, seed = 32'h6d38ddac;
  logic [11:0] addrs [8] = '{12'h400, 12'h404, 12'h408, 12'h40c, 12'h402, 12'h480, 12'h000, 12'hc00};
  int error_cnt = 0, checked = 0, cycles = 0;
  event_type_regs #(.INSTR_RETIRED_CODE(RETIRED)) i_event_type_regs (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_write_ignored(o_write_ignored),
    .i_sysreg_rd(i_sysreg_rd), .i_sysreg_idx(i_sysreg_idx), .o_sysreg_rdata(o_sysreg_rdata),
    .i_architected_counter_count(i_architected_counter_count));
  initial forever #10 i_sys_clk = ~i_sys_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected word for an address and counter count; anything off the three words reads zero
  function automatic logic [31:0] model(input logic [11:0] a, input logic [7:0] c);
    int n;
    n = (a[11:4] == 8'h40 && a[1:0] == 2'b00) ? a[3:2] : 3;
    if (n >= 3 || n >= c) return 32'h0;
    return n == 0 ? 32'h11 : n == 1 ? 32'h4004 : {16'h0, RETIRED};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One bus cycle; answers of the previous cycle are compared at the falling edge
  task automatic cyc(input logic rd, wr, sr, input logic [11:0] a, input logic [1:0] x, input logic [7:0] c);
    @(posedge i_sys_clk);
    i_rd <= rd;
    i_wr <= wr;
    i_sysreg_rd <= sr;
    i_addr <= a;
    i_sysreg_idx <= x;
    i_architected_counter_count <= c;
    i_wdata <= rnd();
    @(negedge i_sys_clk);
    chk("rdata", e_rd, o_rdata);
    chk("write_ignored", {31'h0, e_wi}, {31'h0, o_write_ignored});
    chk("sysreg_rdata", e_sr, o_sysreg_rdata);
    e_rd = rd ? model(a, c) : 32'h0;
    e_wi = wr && model(a, 8'hff) != 32'h0;
    e_sr = sr ? model({8'h40, x, 2'b00}, c) : 32'h0;
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles > 2000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    logic [31:0] r;
    repeat (8) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    for (int c = 0; c < 5; c++) begin
      foreach (addrs[k]) cyc(1'b1, 1'b0, 1'b1, addrs[k], 2'(k), 8'(c));
    end
    $display("test sweep done");
    // Back-to-back mixed traffic; writes carry random data that must never show up
    for (int k = 0; k < 600; k++) begin
      r = rnd();
      cyc(r[0], !r[0] && r[1], r[2], r[5] ? addrs[r[8:6]] : r[31:20], r[10:9], r[3] ? r[19:12] : 8'(r[13:11] % 5));
    end
    cyc(1'b0, 1'b0, 1'b0, 12'h0, 2'h0, 8'h0);
    $display("test random done");
    // Reset lands on the edge that launches a read answer; both views must clear at once
    cyc(1'b1, 1'b0, 1'b1, 12'h400, 2'h0, 8'h3);
    @(posedge i_sys_clk);
    i_rst_b <= 1'b0;
    i_rd <= 1'b0;
    i_sysreg_rd <= 1'b0;
    @(negedge i_sys_clk);
    chk("rdata in reset", 32'h0, o_rdata);
    chk("sysreg_rdata in reset", 32'h0, o_sysreg_rdata);
    repeat (8) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    e_rd = 32'h0;
    e_wi = 1'b0;
    e_sr = 32'h0;
    for (int k = 0; k < 3; k++) begin
      cyc(1'b1, 1'b0, 1'b1, addrs[k], 2'(k), 8'h3);
    end
    cyc(1'b0, 1'b0, 1'b0, 12'h0, 2'h0, 8'h0);
    $display("test reset done");
    close_out();
  end
endmodule
